// ---- design/ecs_clock_select.sv ----
// Purpose: Sample clock selection, termination and range settings
// Assumes: Registers are reached by register number on a simple write/read port
// Notes: Internal clock arrives already generated from the on-board reference
//
// Function
// [RULE1] With external select set the sample clock comes from the connector, else internal.
// [RULE2] Termination bit set to 1 switches in the load only while the connector is an input.
// [RULE3] The outside source supplies at least 1 MHz when clocking directly.
// [RULE4] The outside clock stays below the variant limit of 50 or 100 MS/s.
// [RULE5] The range register accepts codes 2, 4, 8, 16 and 32 only.
// [RULE6] The outside clock stays within 5 % of the chosen range while running.
// [RULE7] Software picks single or small burst at 10 MHz or 5 MHz by channel set.
// [RULE8] In four channel FIFO mode software uses the 2.5/7.5/17.5/36 MHz bounds.
// [RULE9] Software rewrites the range after any channel or mode change.
// [RULE10] A programmed divider divides the outside clock and that becomes the sample clock.
// [RULE11] The divider accepts only 1,2,4,8,10,16,20,40,50,80,100,200,400,500,800,1000,2000.
// [RULE12] With the divider in use the outside clock is faster than 1 MS/s.
// [RULE13] Without external select the sample clock is the internal reference-derived one.
// [RULE14] A divider of 1 passes the outside clock through unchanged.
`timescale 1ns/1ps
module ecs_clock_select #(
   parameter int DIV_W = ecs_pkg::DIV_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   // Clock sources
   input wire logic ext_clk_in,
   input wire logic int_clk_in,
   // Board side
   output logic sample_clk,
   output logic sample_strobe,
   output logic term_enable
);

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      logic ext_sel;
      logic term;
      logic [ecs_pkg::RANGE_W-1:0] range;
      logic [DIV_W-1:0] div;
      logic [31:0] rdata;
      logic rvalid;
      logic smp_prev;
   } ecs_state_t;

   ecs_state_t st_ff;
   ecs_state_t nxt_st;
   logic div_clk;
   logic div_restart;
   logic wr_div_ok;
   logic wr_rng_ok;

   assign wr_div_ok = reg_wr && (reg_addr == ecs_pkg::ADDR_EXT_CLOCK_DIVIDER) &&
                      ecs_pkg::div_valid(reg_wdata);
   assign wr_rng_ok = reg_wr && (reg_addr == ecs_pkg::ADDR_EXT_CLOCK_RANGE) &&
                      ecs_pkg::range_valid(reg_wdata);
   // Restart divider phase on a new ratio or source change
   assign div_restart = wr_div_ok ||
                        (reg_wr && reg_addr == ecs_pkg::ADDR_EXT_CLOCK_SELECT);

   // ***************************************************************
   // Divider
   // ***************************************************************
   ecs_edge_divider #(
      .DIV_W(DIV_W)
   ) u_div (
      .clk(clk),
      .srst(srst),
      .bypass(st_ff.div == ecs_pkg::RST_DIVIDER),
      .restart(div_restart),
      .ratio(st_ff.div),
      .ext_clk(ext_clk_in),
      .div_clk(div_clk)
   );

   // Source mux; the PLL path is outside, only its output is chosen here
   assign sample_clk = st_ff.ext_sel ? div_clk : int_clk_in; // RULE1 RULE13
   assign sample_strobe = sample_clk & ~st_ff.smp_prev;
   // Load only makes sense while the connector receives a clock
   assign term_enable = st_ff.term & st_ff.ext_sel; // RULE2
   assign reg_rdata = st_ff.rdata;
   assign reg_rvalid = st_ff.rvalid;

   // ***************************************************************
   // Register access
   // ***************************************************************
   // Writes of unlisted codes are dropped so the block never runs unconfigured
   always_comb begin
      nxt_st = st_ff;
      nxt_st.smp_prev = sample_clk;
      nxt_st.rvalid = reg_rd;
      if (reg_wr) begin
         case (reg_addr)
            ecs_pkg::ADDR_EXT_CLOCK_SELECT: nxt_st.ext_sel = reg_wdata[0]; // RULE1
            ecs_pkg::ADDR_CLOCK_INPUT_TERM: nxt_st.term = reg_wdata[0]; // RULE2
            ecs_pkg::ADDR_EXT_CLOCK_RANGE: begin
               if (wr_rng_ok) begin
                  nxt_st.range = reg_wdata[ecs_pkg::RANGE_W-1:0]; // RULE5
               end
            end
            ecs_pkg::ADDR_EXT_CLOCK_DIVIDER: begin
               if (wr_div_ok) begin
                  nxt_st.div = reg_wdata[DIV_W-1:0]; // RULE11
               end
            end
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            ecs_pkg::ADDR_EXT_CLOCK_SELECT: nxt_st.rdata = {31'h0, st_ff.ext_sel};
            ecs_pkg::ADDR_CLOCK_INPUT_TERM: nxt_st.rdata = {31'h0, st_ff.term};
            ecs_pkg::ADDR_EXT_CLOCK_RANGE:
               nxt_st.rdata = {{(32-ecs_pkg::RANGE_W){1'b0}}, st_ff.range};
            ecs_pkg::ADDR_EXT_CLOCK_DIVIDER:
               nxt_st.rdata = {{(32-DIV_W){1'b0}}, st_ff.div};
            ecs_pkg::ADDR_CLOCK_STATUS: begin
               nxt_st.rdata = 32'h0;
               nxt_st.rdata[ecs_pkg::STAT_EXT_BIT] = st_ff.ext_sel;
               nxt_st.rdata[ecs_pkg::STAT_CLK_BIT] = sample_clk;
               nxt_st.rdata[ecs_pkg::STAT_TERM_BIT] = term_enable;
            end
            default: nxt_st.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff.ext_sel <= ecs_pkg::RST_EXT_SELECT;
         st_ff.term <= ecs_pkg::RST_TERM;
         st_ff.range <= ecs_pkg::RST_RANGE;
         st_ff.div <= ecs_pkg::RST_DIVIDER;
         st_ff.rdata <= 32'h0;
         st_ff.rvalid <= 1'b0;
         st_ff.smp_prev <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   property p_ext_direct;
      @(posedge clk) disable iff (srst)
      (st_ff.ext_sel && st_ff.div == 11'h001) |-> (sample_clk == ext_clk_in);
   endproperty
   a_ext_direct: assert property (p_ext_direct) // RULE14
      else $error("ratio one does not pass the external clock");

   property p_int_path;
      @(posedge clk) disable iff (srst)
      (reg_wr && reg_addr == ecs_pkg::ADDR_EXT_CLOCK_SELECT && !reg_wdata[0])
      |=> (sample_clk == int_clk_in);
   endproperty
   a_int_path: assert property (p_int_path) // RULE13
      else $error("internal clock not selected after clearing select");

   property p_ext_select;
      @(posedge clk) disable iff (srst)
      (reg_wr && reg_addr == ecs_pkg::ADDR_EXT_CLOCK_SELECT && reg_wdata[0])
      ##1 (st_ff.div == 11'h001) |-> (sample_clk == ext_clk_in);
   endproperty
   a_ext_select: assert property (p_ext_select) // RULE1
      else $error("external clock not selected after setting select");

   property p_term_on;
      @(posedge clk) disable iff (srst)
      (reg_wr && reg_addr == ecs_pkg::ADDR_CLOCK_INPUT_TERM && reg_wdata[0] && st_ff.ext_sel &&
       !(reg_wr && reg_addr == ecs_pkg::ADDR_EXT_CLOCK_SELECT)) |=> term_enable;
   endproperty
   a_term_on: assert property (p_term_on) // RULE2
      else $error("termination not switched in");

   property p_term_input_only;
      @(posedge clk) disable iff (srst)
      !st_ff.ext_sel |-> !term_enable;
   endproperty
   a_term_input_only: assert property (p_term_input_only) // RULE2
      else $error("termination on while connector is not an input");

   property p_range_reject;
      @(posedge clk) disable iff (srst)
      (reg_wr && reg_addr == ecs_pkg::ADDR_EXT_CLOCK_RANGE && !ecs_pkg::range_valid(reg_wdata))
      |=> $stable(st_ff.range);
   endproperty
   a_range_reject: assert property (p_range_reject) // RULE5
      else $error("unlisted range code was stored");

   property p_range_accept;
      @(posedge clk) disable iff (srst)
      wr_rng_ok |=> (st_ff.range == $past(reg_wdata[5:0]));
   endproperty
   a_range_accept: assert property (p_range_accept) // RULE5
      else $error("listed range code not stored");

   property p_div_reject;
      @(posedge clk) disable iff (srst)
      (reg_wr && reg_addr == ecs_pkg::ADDR_EXT_CLOCK_DIVIDER && !ecs_pkg::div_valid(reg_wdata))
      |=> $stable(st_ff.div);
   endproperty
   a_div_reject: assert property (p_div_reject) // RULE11
      else $error("unlisted divider value was stored");

   property p_div_accept;
      @(posedge clk) disable iff (srst)
      wr_div_ok |=> (st_ff.div == $past(reg_wdata[10:0]));
   endproperty
   a_div_accept: assert property (p_div_accept) // RULE11
      else $error("listed divider value not stored");

endmodule

// ---- design/ecs_pkg.sv ----
// Purpose: Shared constants for the external sample clock select block
// Assumes: Register numbers are used directly as addresses on the register port
// Notes: Validity checks for range codes and divider values live here
package ecs_pkg;

   // ***************************************************************
   // Register numbers
   // ***************************************************************
   localparam logic [31:0] ADDR_EXT_CLOCK_SELECT = 32'h0000_4E84; // 20100
   localparam logic [31:0] ADDR_CLOCK_INPUT_TERM = 32'h0000_4E98; // 20120
   localparam logic [31:0] ADDR_EXT_CLOCK_RANGE = 32'h0000_4EA2; // 20130
   localparam logic [31:0] ADDR_EXT_CLOCK_DIVIDER = 32'h0000_4E48; // 20040
   localparam logic [31:0] ADDR_CLOCK_STATUS = 32'h0000_4EE7; // 20199

   // ***************************************************************
   // Field positions and widths
   // ***************************************************************
   localparam int RANGE_W = 6;
   localparam int DIV_W = 11;
   localparam int STAT_EXT_BIT = 0;
   localparam int STAT_CLK_BIT = 1;
   localparam int STAT_TERM_BIT = 2;

   // ***************************************************************
   // Range codes
   // ***************************************************************
   localparam logic [RANGE_W-1:0] RANGE_SINGLE = 6'h02;
   localparam logic [RANGE_W-1:0] RANGE_SMALL_BURST = 6'h04;
   localparam logic [RANGE_W-1:0] RANGE_MEDIUM_BURST = 6'h08;
   localparam logic [RANGE_W-1:0] RANGE_LARGE_BURST = 6'h10;
   localparam logic [RANGE_W-1:0] RANGE_EXTRA_LARGE_BURST = 6'h20;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic RST_EXT_SELECT = 1'h0;
   localparam logic RST_TERM = 1'h0;
   localparam logic [RANGE_W-1:0] RST_RANGE = RANGE_SINGLE;
   localparam logic [DIV_W-1:0] RST_DIVIDER = 11'h001;

   // ***************************************************************
   // Checks
   // ***************************************************************
   // Range code is one of the five accepted codes
   function automatic logic range_valid(input logic [31:0] v);
      range_valid = (v == 32'h02) || (v == 32'h04) || (v == 32'h08) ||
                    (v == 32'h10) || (v == 32'h20);
   endfunction

   // Divider value is one of the seventeen accepted values
   function automatic logic div_valid(input logic [31:0] v);
      case (v)
         32'h1, 32'h2, 32'h4, 32'h8, 32'hA, 32'h10, 32'h14, 32'h28, 32'h32,
         32'h50, 32'h64, 32'hC8, 32'h190, 32'h1F4, 32'h320, 32'h3E8,
         32'h7D0: div_valid = 1'b1;
         default: div_valid = 1'b0;
      endcase
   endfunction

endpackage

// ---- design/ecs_edge_divider.sv ----
// Purpose: Divides the external clock by an even ratio or passes it through
// Assumes: External clock is sampled by clk and is slower than clk/2
// Notes: Output toggles after half the ratio in rising edges
`timescale 1ns/1ps
module ecs_edge_divider #(
   parameter int DIV_W = 11
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Control
   input wire logic bypass,
   input wire logic restart,
   input wire logic [DIV_W-1:0] ratio,
   // Clock in and out
   input wire logic ext_clk,
   output logic div_clk
);

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      logic prev;
      logic [DIV_W-1:0] cnt;
      logic tog;
   } ecs_div_state_t;

   ecs_div_state_t st_ff;
   ecs_div_state_t nxt_st;
   logic rise;
   logic [DIV_W-1:0] half;

   assign rise = ext_clk & ~st_ff.prev;
   assign half = ratio >> 1;

   // Edge counting; a ratio change restarts the phase
   always_comb begin
      nxt_st = st_ff;
      nxt_st.prev = ext_clk;
      if (restart) begin
         nxt_st.cnt = '0;
         nxt_st.tog = 1'b0;
      end else if (rise && !bypass) begin
         if (st_ff.cnt + 1'b1 >= half) begin
            nxt_st.cnt = '0;
            nxt_st.tog = ~st_ff.tog; // RULE10
         end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Ratio one adds no division, only the raw input
   assign div_clk = bypass ? ext_clk : st_ff.tog; // RULE14

   // ***************************************************************
   // Checks
   // ***************************************************************
   property p_div_toggle_on_rise;
      @(posedge clk) disable iff (srst)
      (!bypass && !$past(restart) && $changed(st_ff.tog)) |-> $past(rise);
   endproperty
   a_div_toggle_on_rise: assert property (p_div_toggle_on_rise) // RULE10
      else $error("divided clock toggled without an input edge");

endmodule

// ---- verification/ecs_ext_src.sv ----
// Purpose: Model of the outside clock source feeding the connector
// Assumes: Half period well above two clk periods so clk can see it
// Notes: Line held low while not running, never left at a stale level
`timescale 1ns/1ps
module ecs_ext_src #(
   parameter int HALF_NS = 110
) (
   // Control
   input wire logic run,
   // Connector
   output logic ext_clk
);
   // ***************************************************************
   // Clock generation
   // ***************************************************************
   // Steady 4.5 MHz, above the floor and far below any variant ceiling
   initial begin
      ext_clk = 1'b0;
      // Phase offset keeps line edges off both clk edges, no sampling race
      #5;
      forever begin
         #(HALF_NS) ext_clk = run ? ~ext_clk : 1'b0;
      end
   end
endmodule

// ---- verification/tb.sv ----
// Purpose: Self-checking bench for the sample clock select block
// Assumes: Reads are answered by reg_rvalid one cycle after reg_rd
// Notes: Expected read data is queued by the driver, popped by a monitor
`timescale 1ns/1ps
module tb;
   // ***************************************************************
   // Signals
   // ***************************************************************
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_addr = 32'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata;
   logic reg_rvalid;
   logic ext_clk;
   logic int_clk = 1'b0;
   logic run = 1'b0;
   logic sample_clk;
   logic sample_strobe;
   logic term_enable;
   logic [31:0] expq[$];
   int failures = 0;
   int compares = 0;
   int seed = 32'h2F2EC1EE;
   int ext_cnt = 0;
   int scnt = 0;
   logic [31:0] codes[5] = '{32'h2, 32'h4, 32'h8, 32'h10, 32'h20};
   logic [31:0] divs[17] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'hA, 32'h10, 32'h14,
      32'h28, 32'h32, 32'h50, 32'h64, 32'hC8, 32'h190, 32'h1F4, 32'h320,
      32'h3E8, 32'h7D0};
   logic [31:0] v;
   logic [31:0] e;

   ecs_clock_select i_ecs_clock_select (.clk(clk), .srst(srst), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ext_clk_in(ext_clk),
      .int_clk_in(int_clk), .sample_clk(sample_clk),
      .sample_strobe(sample_strobe), .term_enable(term_enable));
   ecs_ext_src i_ecs_ext_src (.run(run), .ext_clk(ext_clk));

   // ***************************************************************
   // Clock, tasks and monitors
   // ***************************************************************
   // 50 MHz clock
   initial begin
      forever begin
         #10 clk = ~clk;
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle strobe, lowered a full cycle before the next can rise
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] x);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      expq.push_back(x);
      @(negedge clk);
      reg_rd = 1'b0;
   endtask

   task automatic test_done;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Read answers against the oldest note
   always @(posedge clk) begin
      if (reg_rvalid === 1'b1) begin
         if (expq.size() == 0) begin
            failures++;
            $display("[ERR] %0t read answer with nothing pending", $time);
         end else begin
            chk(reg_rdata, expq.pop_front());
         end
      end
      if (sample_strobe === 1'b1) scnt++;
   end

   always @(posedge ext_clk) ext_cnt++;

   // Hang guard, about fourteen times the expected run
   initial begin
      #1000000;
      failures++;
      test_done;
   end

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      repeat (5) @(negedge clk);
      srst = 1'b0;
      // Reset state and an unmapped place
      rd(ecs_pkg::ADDR_EXT_CLOCK_SELECT, 32'h0);
      rd(ecs_pkg::ADDR_CLOCK_INPUT_TERM, 32'h0);
      rd(ecs_pkg::ADDR_EXT_CLOCK_RANGE, 32'h2);
      rd(ecs_pkg::ADDR_EXT_CLOCK_DIVIDER, 32'h1);
      rd(32'h0000_0007, 32'h0);
      // Every range code, then random codes where bad ones are kept out
      e = 32'h20;
      foreach (codes[i]) begin
         wr(ecs_pkg::ADDR_EXT_CLOCK_RANGE, codes[i]);
         rd(ecs_pkg::ADDR_EXT_CLOCK_RANGE, codes[i]);
      end
      repeat (20) begin
         v = $random(seed) & 32'h3F;
         if (v >= 32'h2 && v <= 32'h20 && (v & (v - 32'h1)) == 32'h0) e = v;
         wr(ecs_pkg::ADDR_EXT_CLOCK_RANGE, v);
         rd(ecs_pkg::ADDR_EXT_CLOCK_RANGE, e);
      end
      // Every divider value, then a refused one
      foreach (divs[i]) begin
         wr(ecs_pkg::ADDR_EXT_CLOCK_DIVIDER, divs[i]);
         rd(ecs_pkg::ADDR_EXT_CLOCK_DIVIDER, divs[i]);
      end
      wr(ecs_pkg::ADDR_EXT_CLOCK_DIVIDER, 32'h3);
      rd(ecs_pkg::ADDR_EXT_CLOCK_DIVIDER, 32'h7D0);
      // Load only while the connector is an input
      wr(ecs_pkg::ADDR_CLOCK_INPUT_TERM, 32'h1);
      chk({31'h0, term_enable}, 32'h0);
      wr(ecs_pkg::ADDR_EXT_CLOCK_SELECT, 32'h1);
      chk({31'h0, term_enable}, 32'h1);
      // Status: select set, divided clock held low, load in
      rd(ecs_pkg::ADDR_CLOCK_STATUS, 32'h5);
      wr(ecs_pkg::ADDR_EXT_CLOCK_SELECT, 32'h0);
      chk({31'h0, term_enable}, 32'h0);
      // Internal source passes straight through
      repeat (12) begin
         @(negedge clk);
         int_clk = $random(seed);
         #1 chk({31'h0, sample_clk}, {31'h0, int_clk});
      end
      // External source, direct and divided; range suits 4.5 MHz on one channel
      // Ratio one first, so selecting the connector passes it straight through
      wr(ecs_pkg::ADDR_EXT_CLOCK_DIVIDER, 32'h1);
      wr(ecs_pkg::ADDR_EXT_CLOCK_SELECT, 32'h1);
      // Load written again while the connector is an input
      wr(ecs_pkg::ADDR_CLOCK_INPUT_TERM, 32'h1);
      chk({31'h0, term_enable}, 32'h1);
      wr(ecs_pkg::ADDR_EXT_CLOCK_RANGE, 32'h2);
      run = 1'b1;
      for (int k = 0; k < 4; k++) begin
         wr(ecs_pkg::ADDR_EXT_CLOCK_DIVIDER, divs[k]);
         repeat (4) @(negedge clk);
         ext_cnt = 0;
         scnt = 0;
         repeat (800) begin
            @(negedge clk);
            if (k == 0) chk({31'h0, sample_clk}, {31'h0, ext_clk});
         end
         e = 32'(ext_cnt) / divs[k];
         chk({31'h0, 32'(scnt) + 32'h1 >= e && 32'(scnt) <= e + 32'h1}, 32'h1);
      end
      // Four channels in FIFO mode at 4.5 MHz want the small burst range
      wr(ecs_pkg::ADDR_EXT_CLOCK_RANGE, 32'h4);
      rd(ecs_pkg::ADDR_EXT_CLOCK_RANGE, 32'h4);
      run = 1'b0;
      repeat (4) @(negedge clk);
      // Mid-run reset brings back the defaults
      srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      rd(ecs_pkg::ADDR_EXT_CLOCK_SELECT, 32'h0);
      rd(ecs_pkg::ADDR_EXT_CLOCK_DIVIDER, 32'h1);
      chk({31'h0, term_enable}, 32'h0);
      repeat (4) @(negedge clk);
      chk(32'(expq.size()), 32'h0);
      test_done;
   end
endmodule
